// ### hw/clk_sel_pkg.sv
// Package with register map, field layout and selector codes of the system clock selector
package clk_sel_pkg;
   // ==========================================================================
   // Register byte offsets
   localparam logic [7:0] SYSCTL_OFFSET = 8'h00;
   localparam logic [7:0] PLLCTL_OFFSET = 8'h04;
   localparam logic [7:0] PRESC_OFFSET  = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0c;

   // ==========================================================================
   // Field widths
   localparam int SEL_W   = 2;
   localparam int BAND_W  = 2;
   localparam int PLL_INPUT_DIVIDER_W  = 4;
   localparam int PLL_FEEDBACK_MULTIPLIER_W  = 7;
   localparam int PLL_OUTPUT_DIVIDER_W = 7;
   localparam int PRESCALER_DIVIDER_W = 10;

   // ==========================================================================
   // Field positions in the control words
   localparam int SEL_LSB    = 0;
   localparam int BYP_BIT    = 0;
   localparam int BAND_LSB   = 1;
   localparam int REF_BIT    = 3;
   localparam int PLL_INPUT_DIVIDER_LSB   = 4;
   localparam int PLL_FEEDBACK_MULTIPLIER_LSB   = 8;
   localparam int PLL_OUTPUT_DIVIDER_LSB  = 16;
   localparam int PRESCALER_DIVIDER_LSB  = 0;
   localparam int ST_SEL_LSB = 0;
   localparam int ST_PEND    = 2;
   localparam int ST_LOCK    = 3;
   localparam int ST_PLLON   = 4;

   // ==========================================================================
   // Reset values: wakeup clock, VCO bypassed, dividers at one
   localparam logic [SEL_W-1:0]   SEL_RST   = 2'h0;
   localparam logic               BYP_RST   = 1'h1;
   localparam logic [BAND_W-1:0]  BAND_RST  = 2'h0;
   localparam logic               REF_RST   = 1'h0;
   localparam logic [PLL_INPUT_DIVIDER_W-1:0]  PLL_INPUT_DIVIDER_RST  = 4'h0;
   localparam logic [PLL_FEEDBACK_MULTIPLIER_W-1:0]  PLL_FEEDBACK_MULTIPLIER_RST  = 7'h0;
   localparam logic [PLL_OUTPUT_DIVIDER_W-1:0] PLL_OUTPUT_DIVIDER_RST = 7'h0;
   localparam logic [PRESCALER_DIVIDER_W-1:0] PRESCALER_DIVIDER_RST = 10'h0;

   // ==========================================================================
   // Source selector codes and VCO bands
   localparam logic [SEL_W-1:0]  SEL_WAKEUP = 2'h0;
   localparam logic [SEL_W-1:0]  SEL_PLL    = 2'h2;
   localparam logic [SEL_W-1:0]  SEL_DIRECT = 2'h3;
   localparam logic [BAND_W-1:0] BAND_LOW   = 2'h0;
   localparam logic [BAND_W-1:0] BAND_HIGH  = 2'h1;

   // Path actually driving the system clock
   typedef enum logic [3:0] {
      PATH_WAKEUP = 4'b0001,
      PATH_PRESC  = 4'b0010,
      PATH_PLL    = 4'b0100,
      PATH_DIRECT = 4'b1000
   } path_t;

   // Source switch sequencer
   typedef enum logic [1:0] {
      SW_IDLE = 2'b01,
      SW_WAIT = 2'b10
   } sw_state_t;
endpackage

// ### hw/clk_div_if.sv
// Interface carrying one clock level, its divider field and the divided clock
`timescale 1ns/1ps
interface clk_div_if #(parameter int W = 10);
   logic         src_level;
   logic [W-1:0] div_field;
   logic         clk_out;
   logic         at_wrap;

   modport div (input src_level, input div_field, output clk_out, output at_wrap);
   modport user (output src_level, output div_field, input clk_out, input at_wrap);
endinterface

// ### hw/clk_edge_div.sv
// Divider counting rising edges of a sampled clock level by field plus one
`timescale 1ns/1ps
module clk_edge_div #(
   parameter int W = 10
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   clk_div_if.div    d
);
   logic         prev_ff;
   logic [W-1:0] cnt_ff;
   logic [W-1:0] lim_ff;
   logic         out_ff;
   logic         rise;
   logic         wrap;
   logic [W:0]   half;

   assign rise      = d.src_level & ~prev_ff;
   assign wrap      = rise && (cnt_ff == lim_ff);
   // High phase covers the first ceil(K/2) source periods
   assign half      = ({1'b0, lim_ff} + {{W{1'b0}}, 1'b1} + {{W{1'b0}}, 1'b1}) >> 1;
   assign d.clk_out = out_ff;
   assign d.at_wrap = wrap;

   // ==========================================================================
   // Edge detect
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= d.src_level;
      end
   end

   // ==========================================================================
   // Count; a new divisor is only taken at a period boundary so no runt appears
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_ff <= '0;
         lim_ff <= '0;
      end else if (wrap) begin
         cnt_ff <= '0;
         lim_ff <= d.div_field; // RULE_14
      end else if (rise) begin
         cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // ==========================================================================
   // Output: divide by one follows the source, otherwise count based
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         out_ff <= 1'b0;
      end else if (lim_ff == '0 && !wrap) begin
         out_ff <= d.src_level;
      end else if (wrap) begin
         out_ff <= 1'b1;
      end else if (rise) begin
         out_ff <= ({1'b0, cnt_ff} + {{W{1'b0}}, 1'b1}) < half;
      end
   end
endmodule

// ### hw/system_clock_source_select.sv
// System clock source selector with PLL, prescaler, direct and wakeup paths
//
// Behaviour
// RULE_01 - Selector 10 with VCO bypass 0 enables the PLL and takes the system clock from it.
// RULE_02 - In PLL mode the system clock is the PLL input times N divided by P and K2.
// RULE_03 - Effective input divider, multiplier and output divider are each the field value plus one.
// RULE_04 - The PLL reference is selectable between the crystal pin and the internal oscillator.
// RULE_05 - The system clock in PLL mode is the VCO clock divided by K2, K2 VCO cycles per period.
// RULE_06 - A 2-bit band select picks the VCO band, 00 for the lower and 01 for the higher band.
// RULE_07 - Selector 00 takes the system clock straight from the wakeup oscillator.
// RULE_08 - Software writes source and divider fields in an order that avoids unwanted intermediate setups.
// RULE_09 - Software changes the system clock frequency only in small steps.
// RULE_10 - An external clock is accepted on the crystal pin or on the separate direct clock pin.
// RULE_11 - Selector 11 drives the system clock straight from the direct clock pin.
// RULE_12 - Selector 10 with VCO bypass 1 divides the oscillator clock by K1, the prescaler field plus one.
// RULE_13 - The prescaler divides by up to 1024.
// RULE_14 - Source switches and divider changes cause no runt pulse or glitch on the system clock.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module system_clock_source_select
   import clk_sel_pkg::*;
#(
   parameter int K1_W = PRESCALER_DIVIDER_W,
   parameter int K2_W = PLL_OUTPUT_DIVIDER_W
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 crystal_input,
   input  wire logic                 direct_clock_input,
   input  wire logic                 internal_osc_input,
   input  wire logic                 wakeup_osc_input,
   input  wire logic                 vco_clock_input,
   input  wire logic                 pll_lock_input,
   output logic                      sys_clk,
   output logic                      pll_enable,
   output logic                      pll_ref_select,
   output logic      [BAND_W-1:0]    vco_band_select,
   output logic      [PLL_INPUT_DIVIDER_W:0]      pll_input_divider,
   output logic      [PLL_FEEDBACK_MULTIPLIER_W:0]      pll_feedback_multiplier
);
   // ==========================================================================
   // Synchronisers: every clock and lock pin passes two flops first
   localparam int NSYNC = 6;
   logic [NSYNC-1:0] meta_ff;
   logic [NSYNC-1:0] sync_ff;
   logic             xtal_s;
   logic             direct_s;
   logic             intosc_s;
   logic             wakeup_s;
   logic             vco_s;
   logic             lock_s;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= {pll_lock_input, vco_clock_input, wakeup_osc_input,
                     internal_osc_input, direct_clock_input, crystal_input}; // RULE_10
         sync_ff <= meta_ff;
      end
   end
   assign {lock_s, vco_s, wakeup_s, intosc_s, direct_s, xtal_s} = sync_ff;

   // ==========================================================================
   // Registers
   logic [SEL_W-1:0]   sel_ff;
   logic               byp_ff;
   logic [BAND_W-1:0]  band_ff;
   logic               ref_ff;
   logic [PLL_INPUT_DIVIDER_W-1:0]  pll_input_divider_ff;
   logic [PLL_FEEDBACK_MULTIPLIER_W-1:0]  pll_feedback_multiplier_ff;
   logic [K2_W-1:0]    pll_output_divider_ff;
   logic [K1_W-1:0]    prescaler_divider_ff;
   logic               pready_ff;
   logic               pslverr_ff;
   logic [31:0]        prdata_ff;
   logic               setup;
   logic               wr_en;
   logic               hit;
   logic [31:0]        rd_word;
   path_t              path_ff;
   sw_state_t          sw_ff;

   function automatic logic is_mapped(input logic [7:0] a);
      return a == SYSCTL_OFFSET || a == PLLCTL_OFFSET || a == PRESC_OFFSET || a == STATUS_OFFSET;
   endfunction

   function automatic path_t path_of(input logic [SEL_W-1:0] s, input logic b);
      if (s == SEL_PLL) begin
         return b ? PATH_PRESC : PATH_PLL;
      end else if (s == SEL_DIRECT) begin
         return PATH_DIRECT;
      end
      // Code 01 has no path of its own and falls back to the wakeup clock
      return PATH_WAKEUP;
   endfunction

   assign setup = psel && !penable;
   assign hit   = is_mapped(paddr);
   assign wr_en = psel && penable && pready_ff && pwrite && hit;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         SYSCTL_OFFSET: rd_word[SEL_LSB +: SEL_W] = sel_ff;
         PLLCTL_OFFSET: begin
            rd_word[BYP_BIT]                = byp_ff;
            rd_word[BAND_LSB +: BAND_W]     = band_ff;
            rd_word[REF_BIT]                = ref_ff;
            rd_word[PLL_INPUT_DIVIDER_LSB +: PLL_INPUT_DIVIDER_W]     = pll_input_divider_ff;
            rd_word[PLL_FEEDBACK_MULTIPLIER_LSB +: PLL_FEEDBACK_MULTIPLIER_W]     = pll_feedback_multiplier_ff;
            rd_word[PLL_OUTPUT_DIVIDER_LSB +: K2_W]      = pll_output_divider_ff;
         end
         PRESC_OFFSET:  rd_word[PRESCALER_DIVIDER_LSB +: K1_W] = prescaler_divider_ff;
         STATUS_OFFSET: begin
            rd_word[ST_SEL_LSB +: SEL_W] = (path_ff == PATH_DIRECT) ? SEL_DIRECT :
                                           (path_ff == PATH_WAKEUP) ? SEL_WAKEUP : SEL_PLL;
            rd_word[ST_PEND]             = (sw_ff == SW_WAIT);
            rd_word[ST_LOCK]             = lock_s;
            rd_word[ST_PLLON]            = pll_enable;
         end
         default:       rd_word = 32'h0000_0000;
      endcase
   end

   // ==========================================================================
   // APB slave: answer in the first access cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup && !hit;
         if (setup) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
         end
      end
   end
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign prdata  = prdata_ff;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sel_ff   <= SEL_RST;
         byp_ff   <= BYP_RST;
         band_ff  <= BAND_RST;
         ref_ff   <= REF_RST;
         pll_input_divider_ff  <= PLL_INPUT_DIVIDER_RST;
         pll_feedback_multiplier_ff  <= PLL_FEEDBACK_MULTIPLIER_RST;
         pll_output_divider_ff <= K2_W'(PLL_OUTPUT_DIVIDER_RST);
         prescaler_divider_ff <= K1_W'(PRESCALER_DIVIDER_RST);
      end else if (wr_en) begin
         unique case (paddr)
            SYSCTL_OFFSET: sel_ff <= pwdata[SEL_LSB +: SEL_W];
            PLLCTL_OFFSET: begin
               byp_ff   <= pwdata[BYP_BIT];
               band_ff  <= pwdata[BAND_LSB +: BAND_W];     // RULE_06
               ref_ff   <= pwdata[REF_BIT];                 // RULE_04
               pll_input_divider_ff  <= pwdata[PLL_INPUT_DIVIDER_LSB +: PLL_INPUT_DIVIDER_W];
               pll_feedback_multiplier_ff  <= pwdata[PLL_FEEDBACK_MULTIPLIER_LSB +: PLL_FEEDBACK_MULTIPLIER_W];
               pll_output_divider_ff <= pwdata[PLL_OUTPUT_DIVIDER_LSB +: K2_W];
            end
            PRESC_OFFSET:  prescaler_divider_ff <= pwdata[PRESCALER_DIVIDER_LSB +: K1_W]; // RULE_13
            default:       sel_ff <= sel_ff;
         endcase
      end
   end

   // ==========================================================================
   // Analog PLL controls; the loop itself multiplies by N over P
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pll_enable              <= 1'b0;
         pll_ref_select          <= REF_RST;
         vco_band_select         <= BAND_RST;
         pll_input_divider       <= '0;
         pll_feedback_multiplier <= '0;
      end else begin
         pll_enable              <= (sel_ff == SEL_PLL) && !byp_ff;                  // RULE_01
         pll_ref_select          <= ref_ff;                                           // RULE_04
         vco_band_select         <= band_ff;                                          // RULE_06
         pll_input_divider       <= {1'b0, pll_input_divider_ff} + {{PLL_INPUT_DIVIDER_W{1'b0}}, 1'b1};         // RULE_03 RULE_02
         pll_feedback_multiplier <= {1'b0, pll_feedback_multiplier_ff} + {{PLL_FEEDBACK_MULTIPLIER_W{1'b0}}, 1'b1};         // RULE_03 RULE_02
      end
   end

   // ==========================================================================
   // Divided paths
   clk_div_if #(.W(K1_W)) presc_if ();
   clk_div_if #(.W(K2_W)) pll_if ();

   // Reference swapped only while both sources and the divider output are low, so no short pulse
   logic ref_sel_ff;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ref_sel_ff <= REF_RST;
      end else if (!xtal_s && !intosc_s && !presc_if.clk_out) begin
         ref_sel_ff <= ref_ff; // RULE_14
      end
   end

   assign presc_if.src_level = ref_sel_ff ? intosc_s : xtal_s; // RULE_04 RULE_12
   assign presc_if.div_field = prescaler_divider_ff;                    // RULE_12
   assign pll_if.src_level   = vco_s;
   assign pll_if.div_field   = pll_output_divider_ff;                    // RULE_05

   clk_edge_div #(.W(K1_W)) u_presc (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (presc_if)
   );

   clk_edge_div #(.W(K2_W)) u_k2 (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (pll_if)
   );

   function automatic logic level_of(input path_t p, input logic wk, input logic pr,
                                     input logic pl, input logic dr);
      unique case (p)
         PATH_WAKEUP: return wk;
         PATH_PRESC:  return pr;
         PATH_PLL:    return pl;
         PATH_DIRECT: return dr;
         default:     return 1'b0;
      endcase
   endfunction

   // ==========================================================================
   // Glitch-free switch: change over only while old and new clocks are both low
   path_t target;
   logic  cur_lvl;
   logic  new_lvl;

   assign target  = path_of(sel_ff, byp_ff);
   assign cur_lvl = level_of(path_ff, wakeup_s, presc_if.clk_out, pll_if.clk_out, direct_s);
   assign new_lvl = level_of(target, wakeup_s, presc_if.clk_out, pll_if.clk_out, direct_s);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sw_ff   <= SW_IDLE;
         path_ff <= PATH_WAKEUP;
      end else begin
         unique case (sw_ff)
            SW_IDLE: if (target != path_ff) begin
               sw_ff <= SW_WAIT;
            end
            SW_WAIT: if (target == path_ff) begin
               sw_ff <= SW_IDLE;
            end else if (!cur_lvl && !new_lvl && !sys_clk) begin
               // Output already low for a cycle, so the new clock cannot cut the low phase short
               path_ff <= target; // RULE_14
               sw_ff   <= SW_IDLE;
            end
            default: sw_ff <= SW_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // System clock output; follows the current path, also during a change-over wait
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sys_clk <= 1'b0;
      end else if (sw_ff == SW_WAIT && !cur_lvl) begin
         sys_clk <= 1'b0; // RULE_14
      end else begin
         unique case (path_ff)
            PATH_WAKEUP: sys_clk <= wakeup_s;          // RULE_07
            PATH_PRESC:  sys_clk <= presc_if.clk_out;  // RULE_12
            PATH_PLL:    sys_clk <= pll_if.clk_out;    // RULE_01 RULE_05
            PATH_DIRECT: sys_clk <= direct_s;          // RULE_11
            default:     sys_clk <= 1'b0;
         endcase
      end
   end
endmodule

// ### test/clk_sel_chk.sv
// Port-level assertions for the system clock source selector
`timescale 1ns/1ps
module clk_sel_chk
   import clk_sel_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              sys_clk,
   input wire logic              pll_enable,
   input wire logic              pll_ref_select,
   input wire logic [BAND_W-1:0] vco_band_select,
   input wire logic [PLL_INPUT_DIVIDER_W:0]   pll_input_divider,
   input wire logic [PLL_FEEDBACK_MULTIPLIER_W:0]   pll_feedback_multiplier
);
   // ==========================================================================
   // Cycles since the last completed write, saturating
   logic [1:0] since_wr_ff;

   always_ff @(posedge mclk) begin
      if (!rst_n || (psel && penable && pwrite && pready)) begin
         since_wr_ff <= 2'h0;
      end else if (since_wr_ff != 2'h3) begin
         since_wr_ff <= since_wr_ff + 2'h1;
      end
   end

   // ==========================================================================
   // Properties
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence setup_s;
      psel && !penable;
   endsequence

   sequence access_s;
      psel && penable && pready;
   endsequence

   ready_after_setup_a: assert property (setup_s |=> access_s)
      else $error("pready missing after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_idle_a: assert property (!psel |-> !pready)
      else $error("pready without select");
   err_read_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error response");
   div_nonzero_a: assert property ($past(rst_n) |-> |pll_input_divider && |pll_feedback_multiplier)
      else $error("divider output zero");
   enable_by_write_a: assert property ($changed(pll_enable) |-> since_wr_ff <= 2'h2)
      else $error("pll enable changed without write");
   cfg_by_write_a: assert property ($changed({pll_ref_select, vco_band_select}) |-> since_wr_ff <= 2'h2)
      else $error("pll setup changed without write");
   clk_high_min_a: assert property ($rose(sys_clk) |=> sys_clk)
      else $error("runt high pulse");
   clk_low_min_a: assert property ($fell(sys_clk) |=> !sys_clk)
      else $error("runt low pulse");
endmodule

bind system_clock_source_select clk_sel_chk i_chk (
   .mclk                    (mclk),
   .rst_n                   (rst_n),
   .psel                    (psel),
   .penable                 (penable),
   .pwrite                  (pwrite),
   .prdata                  (prdata),
   .pready                  (pready),
   .pslverr                 (pslverr),
   .sys_clk                 (sys_clk),
   .pll_enable              (pll_enable),
   .pll_ref_select          (pll_ref_select),
   .vco_band_select         (vco_band_select),
   .pll_input_divider       (pll_input_divider),
   .pll_feedback_multiplier (pll_feedback_multiplier)
);

// ### test/clock_far_side.sv
// Oscillators, external clock pins and analog PLL seen from outside the selector
`timescale 1ns/1ps
module clock_far_side (
   output logic      crystal_input,
   output logic      direct_clock_input,
   output logic      internal_osc_input,
   output logic      wakeup_osc_input,
   output logic      vco_clock_input,
   output logic      pll_lock_input,
   input wire logic  pll_enable
);
   // ==========================================================================
   // Free running sources, odd offsets so no edge meets the sampling clock
   initial begin
      crystal_input = 1'b0;
      direct_clock_input = 1'b0;
      internal_osc_input = 1'b0;
      wakeup_osc_input = 1'b0;
      vco_clock_input = 1'b0;
      pll_lock_input = 1'b0;
   end
   initial begin
      #37;
      forever #300 crystal_input = ~crystal_input;
   end
   initial begin
      #23;
      forever #500 direct_clock_input = ~direct_clock_input;
   end
   initial begin
      #13;
      forever #700 internal_osc_input = ~internal_osc_input;
   end
   initial begin
      #71;
      forever #1000 wakeup_osc_input = ~wakeup_osc_input;
   end
   initial begin
      #89;
      forever #300 vco_clock_input = ~vco_clock_input;
   end
   // Lock lags the enable, as a real loop needs time to settle
   always @(pll_enable) pll_lock_input <= #2030 pll_enable;
endmodule

// ### test/testbench.sv
// Register-level bench for the system clock source selector
`timescale 1ns/1ps
module testbench;
   import clk_sel_pkg::*;
   logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr, sys_clk;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic              crystal_input, direct_clock_input, internal_osc_input, wakeup_osc_input;
   logic              vco_clock_input, pll_lock_input, pll_enable, pll_ref_select, er;
   logic [BAND_W-1:0] vco_band_select;
   logic [PLL_INPUT_DIVIDER_W:0]   pll_input_divider;
   logic [PLL_FEEDBACK_MULTIPLIER_W:0]   pll_feedback_multiplier;
   int                errors, n_compared, per;

   // ==========================================================================
   // Clock, partner and design
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   clock_far_side i_far (.crystal_input(crystal_input), .direct_clock_input(direct_clock_input),
      .internal_osc_input(internal_osc_input), .wakeup_osc_input(wakeup_osc_input),
      .vco_clock_input(vco_clock_input), .pll_lock_input(pll_lock_input), .pll_enable(pll_enable));

   system_clock_source_select i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .crystal_input(crystal_input), .direct_clock_input(direct_clock_input),
      .internal_osc_input(internal_osc_input), .wakeup_osc_input(wakeup_osc_input),
      .vco_clock_input(vco_clock_input), .pll_lock_input(pll_lock_input), .sys_clk(sys_clk),
      .pll_enable(pll_enable), .pll_ref_select(pll_ref_select), .vco_band_select(vco_band_select),
      .pll_input_divider(pll_input_divider), .pll_feedback_multiplier(pll_feedback_multiplier));

   // ==========================================================================
   // Bus and compare tasks
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         errors++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk(rd, e);
   endtask

   // Period in mclk cycles, from the second to the third rise once no switch is pending
   task automatic meas(output int p);
      int n, k;
      logic prev;
      p = 0;
      n = 0;
      k = 0;
      // A source change must have landed before a period means anything
      do begin
         xfer(STATUS_OFFSET, 1'b0, 32'h0);
         n++;
      end while (rd[ST_PEND] !== 1'b0 && n < 200);
      if (n >= 200) errors++;
      n = 0;
      prev = sys_clk;
      while (k < 3 && n < 40000) begin
         @(posedge mclk);
         n++;
         p++;
         if (sys_clk === 1'b1 && prev === 1'b0) begin
            k++;
            if (k == 2) p = 0;
         end
         prev = sys_clk;
      end
      if (k < 3) errors++;
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================================================
   // Tests
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      errors = 0;
      n_compared = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      rdc(SYSCTL_OFFSET, 32'h0);
      rdc(PLLCTL_OFFSET, 32'h1);
      rdc(PRESC_OFFSET, 32'h0);
      rdc(STATUS_OFFSET, 32'h0);
      meas(per);
      chk(per, 32'd20);
      xfer(8'h10, 1'b1, 32'hffffffff);
      chk({31'h0, er}, 32'h1);
      xfer(8'h10, 1'b0, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test reset_and_map done");
      // Dividers before the selector, so no odd setup runs in between
      wr(PRESC_OFFSET, 32'h2);
      wr(SYSCTL_OFFSET, 32'h2);
      meas(per);
      chk(per, 32'd18);
      rdc(STATUS_OFFSET, 32'h2);
      wr(PRESC_OFFSET, 32'h3ff);
      rdc(PRESC_OFFSET, 32'h3ff);
      meas(per);
      chk(per, 32'd6144);
      wr(PRESC_OFFSET, 32'h1f);
      meas(per);
      chk(per, 32'd192);
      wr(PRESC_OFFSET, 32'h0);
      meas(per);
      chk(per, 32'd6);
      wr(PLLCTL_OFFSET, 32'h9);
      repeat (30) @(posedge mclk);
      chk({31'h0, pll_ref_select}, 32'h1);
      meas(per);
      chk(per, 32'd14);
      $display("test prescaler done");
      wr(PLLCTL_OFFSET, 32'h00041332);
      repeat (3) @(posedge mclk);
      chk({31'h0, pll_enable}, 32'h1);
      chk({31'h0, pll_ref_select}, 32'h0);
      chk({27'h0, pll_input_divider}, 32'h4);
      chk({24'h0, pll_feedback_multiplier}, 32'h14);
      chk({30'h0, vco_band_select}, 32'h1);
      meas(per);
      chk(per, 32'd30);
      rdc(STATUS_OFFSET, 32'h1a);
      rdc(PLLCTL_OFFSET, 32'h00041332);
      wr(PLLCTL_OFFSET, 32'h00041330);
      repeat (3) @(posedge mclk);
      chk({30'h0, vco_band_select}, 32'h0);
      $display("test pll done");
      wr(SYSCTL_OFFSET, 32'h3);
      meas(per);
      chk(per, 32'd10);
      chk({31'h0, pll_enable}, 32'h0);
      wr(SYSCTL_OFFSET, 32'h1);
      meas(per);
      chk(per, 32'd20);
      wr(SYSCTL_OFFSET, 32'h0);
      meas(per);
      chk(per, 32'd20);
      $display("test direct_and_wakeup done");
      end_of_test();
   end

   // Longest expected run is near 20000 cycles
   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      end_of_test();
   end
endmodule
